// ---- core/irqf_regs.svh ----
`ifndef IRQF_REGS_SVH
`define IRQF_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register map, byte addresses on the cpu data bus
`define IRQF_ADDR_GROUP0_LOW 16'hFFE0
`define IRQF_ADDR_GROUP0_HIGH 16'hFFE1
`define IRQF_ADDR_GROUP1_LOW 16'hFFE2
`define IRQF_ADDR_GROUP1_HIGH 16'hFFE3

// number of byte registers and flags
`define IRQF_NUM_REGS 4
`define IRQF_NUM_FLAGS 32

// reset value of every flag register
`define IRQF_RESET_VALUE 8'h00

// address bits that select the block; the two low bits pick the register
`define IRQF_ADDR_BASE_MASK 16'hFFFC
`define IRQF_ADDR_BASE 16'hFFE0

// value returned for an unmapped read
`define IRQF_UNMAPPED_DATA 16'h0000

`endif

// ---- core/irqf_pkg.sv ----
package irqf_pkg;

  // acknowledge sequencer, one-hot
  typedef enum logic [1:0] {
    IRQF_ACK_IDLE  = 2'b01,
    IRQF_ACK_ENTER = 2'b10
  } irqf_ack_state_t;

  // state of one flag byte
  typedef struct packed {
    logic [7:0] flags;
  } irqf_byte_state_t;

  // state of the top level
  typedef struct packed {
    irqf_ack_state_t ack_state;
    logic ack_done;
    logic rd_valid;
    logic [15:0] rd_data;
  } irqf_top_state_t;

endpackage

// ---- core/irqf_flag_byte.sv ----
`timescale 1ns/100ps
`include "irqf_regs.svh"

// one 8-bit flag register: hardware set, software write, acknowledge clear
module irqf_flag_byte (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] src_set,
  input wire logic [7:0] wr_mask,
  input wire logic [7:0] wr_val,
  input wire logic [7:0] ack_clr,
  output logic [7:0] flags
);

  irqf_pkg::irqf_byte_state_t state_reg;
  irqf_pkg::irqf_byte_state_t state_next;

  //////////////////////////////////////////////////////////////////////////////
  // next value per bit; a source request overrides any clear
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < 8; i++)
    begin
      if (src_set[i])
      begin
        state_next.flags[i] = 1'b1;
      end
      else if (wr_mask[i])
      begin
        state_next.flags[i] = wr_val[i];
      end
      else if (ack_clr[i])
      begin
        state_next.flags[i] = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_reg.flags <= `IRQF_RESET_VALUE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign flags = state_reg.flags;

endmodule // irqf_flag_byte

// ---- core/irqf_top.sv ----
`timescale 1ns/100ps
`include "irqf_regs.svh"

module irqf_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [31:0] src_req,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_word,
  input wire logic bus_bit,
  input wire logic [2:0] bus_bit_sel,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic ack_valid,
  input wire logic [4:0] ack_index,
  output logic ack_done,
  output logic ack_busy,
  output logic [31:0] irq_flags
);

  irqf_pkg::irqf_top_state_t state_reg;
  irqf_pkg::irqf_top_state_t state_next;

  // per-register views of the flags and of their update strobes
  logic [7:0] byte_flags [0:3];
  logic [7:0] wr_mask [0:3];
  logic [7:0] wr_val [0:3];
  logic [7:0] ack_clr [0:3];
  // acknowledge decode
  logic ack_take;
  logic [31:0] ack_onehot;

  //////////////////////////////////////////////////////////////////////////////
  // address decode helpers
  // a register is hit only inside the four-byte window; every bit above
  // the two low address bits must match the base, so aliases never hit

  // true when a byte access at addr hits register idx
  function automatic logic byte_hit(input logic [15:0] addr,
                                    input logic [1:0] idx);
    byte_hit = ((addr & `IRQF_ADDR_BASE_MASK) == `IRQF_ADDR_BASE) &&
               (addr[1:0] == idx);
  endfunction

  // true when a 16-bit access at addr covers register idx
  function automatic logic word_hit(input logic [15:0] addr,
                                    input logic [1:0] idx);
    word_hit = ((addr & `IRQF_ADDR_BASE_MASK) == `IRQF_ADDR_BASE) &&
               (addr[0] == 1'b0) && (addr[1] == idx[1]);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // acknowledge accepted only while the sequencer is idle
  // a request seen while entry is being signalled is dropped, so the
  // processor must present it again once ack_busy has fallen
  assign ack_take = ack_valid &&
                    (state_reg.ack_state == irqf_pkg::IRQF_ACK_IDLE);

  // one-hot clear vector for the acknowledged source
  always_comb
  begin
    ack_onehot = 32'h00000000;
    if (ack_take)
    begin
      ack_onehot[ack_index] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write masks and values per byte register
  // bit writes take precedence over byte and word decode; writes outside
  // the window leave every mask at zero, so no flag moves
  always_comb
  begin
    for (int r = 0; r < `IRQF_NUM_REGS; r++)
    begin
      wr_mask[r] = 8'h00;
      wr_val[r] = 8'h00;
      if (bus_wr)
      begin
        if (bus_bit && byte_hit(bus_addr, 2'(r)))
        begin
          // single-bit manipulation touches one flag only
          wr_mask[r][bus_bit_sel] = 1'b1;
          wr_val[r][bus_bit_sel] = bus_wdata[0];
        end
        else if (!bus_bit && !bus_word && byte_hit(bus_addr, 2'(r)))
        begin
          wr_mask[r] = 8'hFF;
          wr_val[r] = bus_wdata[7:0];
        end
        else if (!bus_bit && bus_word && word_hit(bus_addr, 2'(r)))
        begin
          // even register takes the low lane, odd the high lane
          wr_mask[r] = 8'hFF;
          wr_val[r] = r[0] ? bus_wdata[15:8] : bus_wdata[7:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // four flag bytes; each bit belongs to exactly one source
  genvar g;
  generate
    for (g = 0; g < `IRQF_NUM_REGS; g++)
    begin : gen_byte
      assign ack_clr[g] = ack_onehot[g*8 +: 8];

      // inside each byte: source set, then software write, then ack clear
      irqf_flag_byte u_byte (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .src_set(src_req[g*8 +: 8]),
        .wr_mask(wr_mask[g]),
        .wr_val(wr_val[g]),
        .ack_clr(ack_clr[g]),
        .flags(byte_flags[g])
      );

      assign irq_flags[g*8 +: 8] = byte_flags[g];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read path and acknowledge sequencer
  always_comb
  begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.ack_done = 1'b0;

    // reads return the flags as they stood before this edge
    // a word read at an odd address, or outside the window, answers zero;
    // the upper lane of a byte read is always zero
    if (bus_rd)
    begin
      state_next.rd_valid = 1'b1;
      state_next.rd_data = `IRQF_UNMAPPED_DATA;
      if (bus_word)
      begin
        if (word_hit(bus_addr, 2'd0))
        begin
          state_next.rd_data = {byte_flags[1], byte_flags[0]};
        end
        else if (word_hit(bus_addr, 2'd2))
        begin
          state_next.rd_data = {byte_flags[3], byte_flags[2]};
        end
      end
      else
      begin
        for (int r = 0; r < `IRQF_NUM_REGS; r++)
        begin
          if (byte_hit(bus_addr, 2'(r)))
          begin
            state_next.rd_data = {8'h00, byte_flags[r]};
          end
        end
      end
    end

    // clear lands at the taking edge, and entry is signalled at that same edge
    case (state_reg.ack_state)
      irqf_pkg::IRQF_ACK_IDLE:
      begin
        // take one acknowledge; its flag clears at this same edge
        if (ack_take)
        begin
          state_next.ack_state = irqf_pkg::IRQF_ACK_ENTER;
          state_next.ack_done = 1'b1;
        end
      end
      irqf_pkg::IRQF_ACK_ENTER:
      begin
        // service entry stays visible for exactly one cycle
        state_next.ack_state = irqf_pkg::IRQF_ACK_IDLE;
      end
      default:
      begin
        state_next.ack_state = irqf_pkg::IRQF_ACK_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // top state register, synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_reg.ack_state <= irqf_pkg::IRQF_ACK_IDLE;
      state_reg.ack_done <= 1'b0;
      state_reg.rd_valid <= 1'b0;
      state_reg.rd_data <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  // read data holds its last value until the next read is answered
  assign bus_rdata = state_reg.rd_data;
  assign bus_rvalid = state_reg.rd_valid;
  assign ack_done = state_reg.ack_done;
  // the one-hot enter bit itself, so no decode sits behind this output
  assign ack_busy = state_reg.ack_state[1];

endmodule // irqf_top

// ---- test/irqf_checker.sv ----
`timescale 1ns/100ps

// port-level checks of the flag block
module irqf_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [31:0] src_req,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_word,
  input wire logic bus_bit,
  input wire logic [2:0] bus_bit_sel,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic ack_valid,
  input wire logic [4:0] ack_index,
  input wire logic ack_done,
  input wire logic ack_busy,
  input wire logic [31:0] irq_flags
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // flag updates
  a_src_sets: assert property (
    1 |=> (irq_flags & $past(src_req)) == $past(src_req))
    else $error("source request did not set its flag");
  a_ack_clears: assert property (
    ack_valid && !ack_busy && !bus_wr && src_req == 32'h0 |=>
    ack_done && !irq_flags[$past(ack_index)])
    else $error("acknowledge did not clear the flag");
  a_ack_pulse: assert property (
    ack_done |-> ack_busy && $past(ack_valid) ##1 !ack_done)
    else $error("acknowledge completion malformed");
  a_bit_write: assert property (
    bus_wr && bus_bit && bus_addr[15:2] == 14'h3FF8 && src_req == 32'h0 &&
    !ack_valid |=>
    irq_flags[{$past(bus_addr[1:0]), $past(bus_bit_sel)}] ==
    $past(bus_wdata[0]))
    else $error("single bit write lost");
  a_reset_zero: assert property (disable iff (1'b0)
    !reset_n |=> irq_flags == 32'h0 && !bus_rvalid && !ack_done)
    else $error("reset did not clear state");

  ////////////////////////////////////////////////////////////////////////////
  // read path
  a_read_answer: assert property (
    1 |=> bus_rvalid == $past(bus_rd))
    else $error("read answer not one cycle later");
  a_word_read: assert property (
    bus_rd && bus_word && bus_addr == 16'hFFE0 |=>
    bus_rdata == $past(irq_flags[15:0]))
    else $error("word read of group zero wrong");
  a_low_read: assert property (
    bus_rd && !bus_word && bus_addr == 16'hFFE0 |=>
    bus_rdata == {8'h00, $past(irq_flags[7:0])})
    else $error("byte read at base wrong");
  a_unmapped: assert property (
    bus_rd && bus_addr[15:2] != 14'h3FF8 |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule // irqf_checker

////////////////////////////////////////////////////////////////////////////////
bind irqf_top irqf_checker chk (.core_clk, .reset_n, .src_req, .bus_addr,
  .bus_rd, .bus_wr, .bus_word, .bus_bit, .bus_bit_sel, .bus_wdata,
  .bus_rdata, .bus_rvalid, .ack_valid, .ack_index, .ack_done, .ack_busy,
  .irq_flags);

// ---- test/irqf_cpu_model.sv ----
`timescale 1ns/100ps

// processor side: acknowledges one flag, promptly or late
module irqf_cpu_model (
  input wire logic core_clk,
  input wire logic ack_done,
  output logic ack_valid,
  output logic [4:0] ack_index,
  output logic ack_ok
);
  // idle values at time zero
  initial
  begin
    ack_valid = 1'b0;
    ack_index = 5'h00;
    ack_ok = 1'b1;
  end

  // hold the request until completion is sampled, bounded wait
  task automatic ack(input logic [4:0] idx, input int delay);
    int n;
    n = 0;
    repeat (delay + 1) @(posedge core_clk); // raise only on a clock edge
    ack_valid <= 1'b1;
    ack_index <= idx;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack_done !== 1'b1 && n < 8);
    ack_ok = (ack_done === 1'b1);
    ack_valid <= 1'b0;
    ack_index <= ~idx; // stale index is not left on the lines
  endtask
endmodule // irqf_cpu_model

// ---- test/test_irqf_top.sv ----
`timescale 1ns/100ps

// random and corner checks of the flag block
module test_irqf_top;
  logic core_clk, reset_n, bus_rd, bus_wr, bus_word, bus_bit, ack_valid;
  logic ack_done, ack_busy, bus_rvalid, ack_ok;
  logic [31:0] src_req, irq_flags, exp, seed;
  logic [15:0] bus_addr, bus_wdata, bus_rdata;
  logic [2:0] bus_bit_sel;
  logic [4:0] ack_index, k;
  int err_total, total_checks;

  irqf_top dut (.core_clk, .reset_n, .src_req, .bus_addr, .bus_rd, .bus_wr,
    .bus_word, .bus_bit, .bus_bit_sel, .bus_wdata, .bus_rdata, .bus_rvalid,
    .ack_valid, .ack_index, .ack_done, .ack_busy, .irq_flags);
  irqf_cpu_model cpu (.core_clk, .ack_done, .ack_valid, .ack_index, .ack_ok);

  ////////////////////////////////////////////////////////////////////////////
  // clock, helpers
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] put(input logic [31:0] f,
    input logic [1:0] b, input logic [7:0] d);
    put = f;
    put[b * 8 +: 8] = d;
  endfunction

  // one bus access with a same-cycle source pattern
  task automatic acc(input logic rd, wr, wd, bt, input logic [2:0] sel,
    input logic [15:0] a, d, input logic [31:0] s);
    @(posedge core_clk);
    {bus_rd, bus_wr, bus_word, bus_bit} <= {rd, wr, wd, bt};
    {bus_bit_sel, bus_addr, bus_wdata, src_req} <= {sel, a, d, s};
    @(posedge core_clk);
    {bus_rd, bus_wr, src_req} <= {2'b00, 32'h0};
    #1;
  endtask

  task automatic chk(input logic [31:0] got, want);
    total_checks++;
    if (got !== want)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {reset_n, bus_rd, bus_wr, bus_word, bus_bit, bus_bit_sel} = 8'h00;
    {bus_addr, bus_wdata, src_req, exp} = 96'h0;
    {err_total, total_checks, seed} = {64'h0, 32'hB7E365B1};
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    #1 chk(irq_flags, 32'h0);
    acc(1, 0, 0, 0, 0, 16'hFFE0, 16'h0, 0);
    chk({16'h0, bus_rdata}, 32'h0);
    chk({31'h0, bus_rvalid}, 32'h1);
    $display("reset test done");
    repeat (12)
    begin
      seed = lfsr(seed);
      acc(0, 1, 0, 0, 0, 16'hFFE0 + seed[1:0], seed[23:8], 0);
      exp = put(exp, seed[1:0], seed[15:8]);
      chk(irq_flags, exp);
    end
    acc(1, 0, 1, 0, 0, 16'hFFE0, 16'h0, 0);
    chk({16'h0, bus_rdata}, {16'h0, exp[15:0]});
    acc(1, 0, 1, 0, 0, 16'hFFE2, 16'h0, 0);
    chk({16'h0, bus_rdata}, {16'h0, exp[31:16]});
    seed = lfsr(seed);
    acc(0, 1, 1, 0, 0, 16'hFFE2, seed[15:0], 0);
    exp[31:16] = seed[15:0];
    chk(irq_flags, exp);
    $display("byte and word test done");
    repeat (10)
    begin
      seed = lfsr(seed);
      k = seed[4:0];
      acc(0, 1, 0, 1, k[2:0], 16'hFFE0 + k[4:3], {15'h0, seed[5]}, 0);
      exp[k] = seed[5];
      chk(irq_flags, exp);
    end
    repeat (4)
    begin
      seed = lfsr(seed);
      acc(0, 1, 0, 0, 0, 16'hFFE0 + seed[1:0], 16'h0, seed);
      exp = put(exp, seed[1:0], 8'h00) | seed;
      chk(irq_flags, exp);
    end
    $display("bit and source test done");
    repeat (4)
    begin
      seed = lfsr(seed);
      k = seed[4:0];
      acc(0, 1, 0, 1, k[2:0], 16'hFFE0 + k[4:3], 16'h0001, 0);
      cpu.ack(k, seed[7:6]);
      exp[k] = 1'b0;
      #1 chk({31'h0, ack_ok}, 32'h1);
      chk(irq_flags, exp);
    end
    $display("acknowledge test done");
    acc(1, 0, 0, 0, 0, 16'hFFE4, 16'h0, 0);
    chk({16'h0, bus_rdata}, 32'h0);
    acc(1, 0, 1, 0, 0, 16'hFFE1, 16'h0, 0);
    chk({16'h0, bus_rdata}, 32'h0);
    acc(0, 1, 0, 0, 0, 16'hFFE5, 16'h00FF, 0);
    chk(irq_flags, exp);
    $display("unmapped test done");
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    #1 chk(irq_flags, 32'h0);
    $display("second reset test done");
    results();
  end
endmodule // test_irqf_top
